// ---- tcg_pkg.sv ----
// Package with constants, field positions and types of the generator
`default_nettype none
package tcg_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int CARRIER_US      = 1000;      // One carrier period, 1 kHz
    localparam int CARRIER_CYC     = (CLK_HZ / 1_000_000) * CARRIER_US;
    localparam int PERIODS_PER_BIT = 10;        // Carrier periods per symbol
    localparam int BITS_PER_FRAME  = 100;       // 100 symbols per second
    localparam int ZERO_HIGH       = 2;         // Mark periods for binary 0
    localparam int ONE_HIGH        = 5;         // Mark periods for binary 1
    localparam int MARK_HIGH       = 8;         // Mark periods for a marker

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  STATUS_OFS = 8'h04;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0045;
    localparam int CTRL_MODE_POS   = 0;         // Four bit mode field
    localparam int CTRL_ODD_POS    = 4;         // Odd frame parity
    localparam int CTRL_QDIS_POS   = 5;         // Quality field forced zero
    localparam int CTRL_EN_POS     = 6;         // Generator enable
    localparam int STAT_BIT_POS    = 0;         // Seven bit symbol index
    localparam int STAT_SYNC_POS   = 7;         // Synchronised since reset
    localparam int STAT_RUN_POS    = 8;         // Frame in progress
    localparam int STAT_PER_POS    = 9;         // Four bit period index

    // ------------------------------------------------------------
    // Frame field positions
    // ------------------------------------------------------------
    localparam int SEC_LO_POS   = 1;
    localparam int SEC_HI_POS   = 6;
    localparam int MIN_LO_POS   = 10;
    localparam int MIN_HI_POS   = 15;
    localparam int HR_LO_POS    = 20;
    localparam int HR_HI_POS    = 25;
    localparam int DAY_LO_POS   = 30;
    localparam int DAY_MID_POS  = 35;
    localparam int DAY_HI_POS   = 40;
    localparam int YEAR_LO_POS  = 50;
    localparam int YEAR_PAD_POS = 54;
    localparam int YEAR_HI_POS  = 55;
    localparam int LEAP_PEND_POS = 60;
    localparam int LEAP_DIR_POS  = 61;
    localparam int SAVE_PEND_POS = 62;
    localparam int SUMMER_POS    = 63;
    localparam int TZ_SIGN_POS   = 64;
    localparam int TZ_HR_POS     = 65;
    localparam int TZ_HALF_POS   = 70;
    localparam int QUAL_POS      = 71;
    localparam int PARITY_POS    = 75;
    localparam int DOM_POS       = 60;
    localparam int MONTH_POS     = 70;
    localparam int SBS_LO_POS    = 80;
    localparam int SBS_HI_POS    = 90;
    localparam logic [6:0] LAST_MIN_BCD = 7'h59;
    localparam logic [3:0] QUAL_LOCKED  = 4'h0;
    localparam logic [3:0] QUAL_FAILED  = 4'hF;

    // ------------------------------------------------------------
    // Modes, states, time and status types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TCG_B002  = 4'h0,
        TCG_B003  = 4'h1,
        TCG_B006  = 4'h2,
        TCG_B007  = 4'h3,
        TCG_AFNOR = 4'h4,
        TCG_IEEE  = 4'h5,
        TCG_C37   = 4'h6
    } tcg_mode_type;

    typedef enum logic [1:0] {
        TCG_ST_IDLE = 2'b00,
        TCG_ST_RUN  = 2'b01
    } tcg_state_type;

    typedef struct packed {
        logic [6:0]  sec;        // BCD seconds
        logic [6:0]  min;        // BCD minutes
        logic [5:0]  hour;       // BCD hours
        logic [9:0]  doy;        // BCD day of year
        logic [7:0]  year;       // BCD year of century
        logic [5:0]  dom;        // BCD day of month
        logic [4:0]  month;      // BCD month
        logic [16:0] sbs;        // Binary seconds of day
    } tcg_time_type;

    typedef struct packed {
        logic       leap_pending_flag;
        logic       saving_pending;
        logic       summer_time_flag;
        logic       tz_minus;
        logic [3:0] tz_hours;
        logic       tz_half;
        logic       never_synced;
    } tcg_status_type;
endpackage
`default_nettype wire

// ---- tcg_time_code_generator.sv ----
// Serial time code generator: frame builder, symbol timing and registers
//
// Summary of operation
// - Markers 49,59,69; year BCD; bit 54 zero
// - Leap pending only in final 59 seconds
// - Leap direction bit always add
// - Saving pending only in final 59 seconds
// - Summer time bit follows summer time
// - Offset sign bit 64, hours bits 65-68
// - Bit 70 marks extra half hour
// - Quality figure in bits 71 to 74
// - Bit 75 parity over preceding bits
// - Quality 0000 synced once, else 1111
// - Synced flag sticky until power-up reset
// - Test setting forces quality bits zero
// - One hundred symbols every second
// - Variants add binary seconds and year
// - Level shift and AM mark share frame
// - 1 kHz carrier, ten periods per symbol
// - Mark periods 2, 5 or 8 first
// - C37 mode inverts offset sign bit
// - AFNOR sends year, date and seconds
`timescale 1ns/1ps
`default_nettype none
module tcg_time_code_generator
    import tcg_pkg::*;
#(
    parameter int CARRIER_CYCLES = CARRIER_CYC
) (
    input  wire logic           clk_in,
    input  wire logic           reset_in,
    input  wire logic           sec_start_in,
    input  wire tcg_time_type   time_in,
    input  wire tcg_status_type status_in,
    input  wire logic [7:0]     reg_addr_in,
    input  wire logic [31:0]    reg_wdata_in,
    input  wire logic           reg_write_in,
    input  wire logic           reg_read_in,
    output logic [31:0]         reg_rdata_out,
    output logic                level_shift_output,
    output logic                am_mark_out,
    output logic                carrier_out,
    output logic                frame_start_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int CW = $clog2(CARRIER_CYCLES);
    localparam logic [CW-1:0] CYC_LAST = CW'(CARRIER_CYCLES - 1);
    localparam logic [CW-1:0] CYC_HALF = CW'(CARRIER_CYCLES / 2);
    localparam logic [3:0]    PER_LAST = 4'(PERIODS_PER_BIT - 1);
    localparam logic [6:0]    BIT_LAST = 7'(BITS_PER_FRAME - 1);

    logic [31:0]    ctrl_r;
    logic [31:0]    reg_rdata_r;
    tcg_state_type  state_r;
    logic [CW-1:0]  cyc_r;
    logic [3:0]     per_r;
    logic [6:0]     bit_r;
    tcg_time_type   tlat_r;
    tcg_status_type slat_r;
    logic           synced_once_r;
    logic           level_r;
    logic           mark_r;
    logic           carrier_r;
    logic           fstart_r;
    logic [99:0]    frame_data;
    logic [99:0]    marker_mask;
    logic [3:0]     high_count;
    logic [3:0]     per_nxt;
    logic           last_cycle;
    logic           end_of_bit;
    logic           end_of_frame;
    logic           run_en;
    logic           final_minute;
    logic [3:0]     quality;
    tcg_mode_type   mode;

    assign mode = tcg_mode_type'(ctrl_r[CTRL_MODE_POS +: 4]);
    assign run_en = ctrl_r[CTRL_EN_POS];

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Control register write
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r <= CTRL_RST;
        end else if (reg_write_in && reg_addr_in == CTRL_OFS) begin
            ctrl_r <= {25'h000_0000, reg_wdata_in[6:0]};
        end
    end

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                CTRL_OFS: begin
                    reg_rdata_r <= ctrl_r;
                end
                STATUS_OFS: begin
                    reg_rdata_r <= {19'h0_0000, per_r,
                                    state_r == TCG_ST_RUN,
                                    synced_once_r, bit_r};
                end
                default: begin
                    reg_rdata_r <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata_r <= 32'h0000_0000;
        end
    end
    assign reg_rdata_out = reg_rdata_r;

    // ------------------------------------------------------------
    // Synchronisation history
    // ------------------------------------------------------------
    // Set on first sync, cleared only by reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            synced_once_r <= 1'b0;
        end else if (!status_in.never_synced) begin
            synced_once_r <= 1'b1;
        end
    end

    // Quality figure, forced zero in test setting
    always_comb begin
        if (ctrl_r[CTRL_QDIS_POS]) begin
            quality = 4'h0;
        end else if (synced_once_r) begin
            quality = QUAL_LOCKED;
        end else begin
            quality = QUAL_FAILED;
        end
    end

    // ------------------------------------------------------------
    // Symbol timing
    // ------------------------------------------------------------
    assign last_cycle   = (cyc_r == CYC_LAST);
    assign end_of_bit   = last_cycle && (per_r == PER_LAST);
    assign end_of_frame = end_of_bit && (bit_r == BIT_LAST);
    assign per_nxt      = last_cycle ? per_r + 4'h1 : per_r;

    // Frame sequencer, restarted by every second strobe
    always_ff @(posedge clk_in) begin
        if (reset_in || !run_en) begin
            state_r <= TCG_ST_IDLE;
            cyc_r   <= '0;
            per_r   <= 4'h0;
            bit_r   <= 7'h00;
        end else begin
            case (state_r)
                TCG_ST_IDLE: begin
                    if (sec_start_in) begin
                        state_r <= TCG_ST_RUN;
                    end
                end
                TCG_ST_RUN: begin
                    if (sec_start_in) begin
                        cyc_r <= '0;
                        per_r <= 4'h0;
                        bit_r <= 7'h00;
                    end else if (end_of_frame) begin
                        state_r <= TCG_ST_IDLE;
                        cyc_r   <= '0;
                        per_r   <= 4'h0;
                        bit_r   <= 7'h00;
                    end else if (end_of_bit) begin
                        cyc_r <= '0;
                        per_r <= 4'h0;
                        bit_r <= bit_r + 7'h01;
                    end else begin
                        cyc_r <= last_cycle ? '0 : cyc_r + 1'b1;
                        per_r <= per_nxt;
                    end
                end
                default: begin
                    state_r <= TCG_ST_IDLE;
                end
            endcase
        end
    end

    // Latch time and status at the start of each frame
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tlat_r <= '0;
            slat_r <= '0;
        end else if (sec_start_in) begin
            tlat_r <= time_in;
            slat_r <= status_in;
        end
    end

    // ------------------------------------------------------------
    // Frame content
    // ------------------------------------------------------------
    // Marker positions: reference, then every tenth bit ending in 9
    always_comb begin
        marker_mask = '0;
        marker_mask[0] = 1'b1;
        for (int k = 1; k <= 10; k++) begin
            marker_mask[k*10-1] = 1'b1;
        end
    end

    assign final_minute = (tlat_r.min == LAST_MIN_BCD) &&
                          (tlat_r.sec != 7'h00);

    // Binary content of the frame for the selected mode
    always_comb begin
        frame_data = '0;
        frame_data[SEC_LO_POS +: 4]  = tlat_r.sec[3:0];
        frame_data[SEC_HI_POS +: 3]  = tlat_r.sec[6:4];
        frame_data[MIN_LO_POS +: 4]  = tlat_r.min[3:0];
        frame_data[MIN_HI_POS +: 3]  = tlat_r.min[6:4];
        frame_data[HR_LO_POS +: 4]   = tlat_r.hour[3:0];
        frame_data[HR_HI_POS +: 2]   = tlat_r.hour[5:4];
        frame_data[DAY_LO_POS +: 4]  = tlat_r.doy[3:0];
        frame_data[DAY_MID_POS +: 4] = tlat_r.doy[7:4];
        frame_data[DAY_HI_POS +: 2]  = tlat_r.doy[9:8];
        // Year in all modes other than B002 and B003
        if (mode != TCG_B002 && mode != TCG_B003) begin
            frame_data[YEAR_LO_POS +: 4] = tlat_r.year[3:0];
            frame_data[YEAR_PAD_POS]     = 1'b0;
            frame_data[YEAR_HI_POS +: 4] = tlat_r.year[7:4];
        end
        // Straight binary seconds of day
        if (mode != TCG_B002 && mode != TCG_B006) begin
            frame_data[SBS_LO_POS +: 9] = tlat_r.sbs[8:0];
            frame_data[SBS_HI_POS +: 8] = tlat_r.sbs[16:9];
        end
        case (mode)
            TCG_AFNOR: begin
                frame_data[DOM_POS +: 4]    = tlat_r.dom[3:0];
                frame_data[DOM_POS+4 +: 2]  = tlat_r.dom[5:4];
                frame_data[MONTH_POS +: 5]  = tlat_r.month;
            end
            TCG_IEEE, TCG_C37: begin
                frame_data[LEAP_PEND_POS] = slat_r.leap_pending_flag &&
                                            final_minute;
                frame_data[LEAP_DIR_POS]  = 1'b0;
                frame_data[SAVE_PEND_POS] = slat_r.saving_pending &&
                                            final_minute;
                frame_data[SUMMER_POS]    = slat_r.summer_time_flag;
                frame_data[TZ_SIGN_POS]   = slat_r.tz_minus ^
                                            (mode == TCG_C37);
                frame_data[TZ_HR_POS +: 4] = slat_r.tz_hours;
                frame_data[TZ_HALF_POS]    = slat_r.tz_half;
                frame_data[QUAL_POS +: 4]  = quality;
                // Parity over bits 0 to 74, odd sense when selected
                frame_data[PARITY_POS] = ^{ctrl_r[CTRL_ODD_POS],
                    frame_data[PARITY_POS-1:0]};
            end
            default: begin
                frame_data[PARITY_POS] = 1'b0;
            end
        endcase
    end

    // Mark period count of the current symbol
    always_comb begin
        if (marker_mask[bit_r]) begin
            high_count = 4'(MARK_HIGH);
        end else if (frame_data[bit_r]) begin
            high_count = 4'(ONE_HIGH);
        end else begin
            high_count = 4'(ZERO_HIGH);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Both streams driven from the same symbol and period count
    always_ff @(posedge clk_in) begin
        if (reset_in || state_r != TCG_ST_RUN) begin
            level_r   <= 1'b0;
            mark_r    <= 1'b0;
            carrier_r <= 1'b0;
        end else begin
            level_r   <= (per_r < high_count);
            mark_r    <= (per_r < high_count);
            carrier_r <= (cyc_r < CYC_HALF);
        end
    end

    // Pulse at the reference marker of each frame
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fstart_r <= 1'b0;
        end else begin
            fstart_r <= (state_r == TCG_ST_RUN) && (bit_r == 7'h00) &&
                        (per_r == 4'h0) && (cyc_r == '0);
        end
    end

    assign level_shift_output = level_r;
    assign am_mark_out        = mark_r;
    assign carrier_out        = carrier_r;
    assign frame_start_out    = fstart_r;
endmodule
`default_nettype wire

// ---- tcg_time_code_generator_properties.sv ----
// Port checks of the time code generator, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tcg_time_code_generator_properties
    import tcg_pkg::*;
#(
    parameter int CARRIER_CYCLES = CARRIER_CYC
) (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        sec_start_in,
    input wire logic        reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        level_shift_output,
    input wire logic        am_mark_out,
    input wire logic        carrier_out,
    input wire logic        frame_start_out
);
    localparam int CC = CARRIER_CYCLES;
    int lvl_cnt;
    int car_cnt;
    int gap_cnt;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Length of the present high run of level and carrier
    always_ff @(posedge clk_in) begin
        lvl_cnt <= level_shift_output ? lvl_cnt + 1 : 0;
        car_cnt <= carrier_out ? car_cnt + 1 : 0;
    end
    // Cycles since the last symbol boundary
    always_ff @(posedge clk_in) begin
        gap_cnt <= $rose(level_shift_output) ? 1 : gap_cnt + 1;
    end

    sequence s_frame_open;
        $rose(frame_start_out);
    endsequence
    sequence s_marker_head;
        level_shift_output && am_mark_out && carrier_out
            ##1 level_shift_output [*8];
    endsequence

    a_first_marker: assert property (s_frame_open |-> s_marker_head)
        else $error("frame does not open with a marker");
    a_level_am_match: assert property (
        level_shift_output == am_mark_out)
        else $error("level shift and amplitude streams differ");
    a_mark_widths: assert property (
        $fell(level_shift_output) |-> lvl_cnt inside {2 * CC, 5 * CC, 8 * CC})
        else $error("mark part has an illegal length");
    a_symbol_spacing: assert property (
        $rose(level_shift_output) && !frame_start_out |->
            gap_cnt == PERIODS_PER_BIT * CC)
        else $error("symbol boundary spacing wrong");
    a_carrier_half: assert property (
        $fell(carrier_out) |-> car_cnt == CC / 2)
        else $error("carrier high half has wrong length");
    a_launch_delay: assert property (
        frame_start_out |-> $past(sec_start_in, 2))
        else $error("frame opened without a second strobe");
    a_start_single: assert property (frame_start_out |=> !frame_start_out)
        else $error("frame start pulse too long");
    a_read_data_idle: assert property (
        reg_rdata_out != 32'h0000_0000 |-> $past(reg_read_in))
        else $error("read data outside the answer cycle");
endmodule

bind tcg_time_code_generator tcg_time_code_generator_properties #(
    .CARRIER_CYCLES(CARRIER_CYCLES)
) u_props (
    .clk_in(clk_in), .reset_in(reset_in), .sec_start_in(sec_start_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .level_shift_output(level_shift_output), .am_mark_out(am_mark_out),
    .carrier_out(carrier_out), .frame_start_out(frame_start_out)
);
`default_nettype wire

// ---- tcg_rx_model.sv ----
// Receiver model that decodes the level shift stream into symbols
`timescale 1ns/1ps
`default_nettype none
module tcg_rx_model
    import tcg_pkg::*;
#(
    parameter int CARRIER_CYCLES = 10
) (
    input  wire logic clk_in,
    input  wire logic level_in,
    input  wire logic frame_start_in,
    output var int    frames_out
);
    localparam int CC = CARRIER_CYCLES;
    logic [1:0] sym [BITS_PER_FRAME]; // 0, 1, marker 2, bad width 3
    logic       prev_r = 1'b0;
    int         idx_r  = 0;
    int         high_r = 0;
    initial frames_out = 0;

    // Index a symbol at its rise, classify it by mark length at its fall
    always @(posedge clk_in) begin
        prev_r <= level_in;
        high_r <= level_in ? high_r + 1 : 0;
        if (level_in && !prev_r)
            idx_r <= frame_start_in ? 0 : idx_r + 1;
        if (!level_in && prev_r && idx_r < BITS_PER_FRAME) begin
            sym[idx_r] <= (high_r == 2 * CC) ? 2'd0 :
                          (high_r == 5 * CC) ? 2'd1 :
                          (high_r == 8 * CC) ? 2'd2 : 2'd3;
            if (idx_r == BITS_PER_FRAME - 1)
                frames_out <= frames_out + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tcg_time_code_generator_test.sv ----
// Self-checking testbench of the time code generator
`timescale 1ns/1ps
`default_nettype none
module tcg_time_code_generator_test
    import tcg_pkg::*;
;
    localparam int CC        = 10;
    localparam int FRAME_CYC = BITS_PER_FRAME * PERIODS_PER_BIT * CC;
    logic           clk_in       = 1'b0;
    logic           reset_in     = 1'b1;
    logic           sec_start_in = 1'b0;
    logic           reg_write_in = 1'b0;
    logic           reg_read_in  = 1'b0;
    logic [7:0]     reg_addr_in  = 8'h00;
    logic [31:0]    reg_wdata_in = 32'h0000_0000;
    tcg_time_type   time_in;
    tcg_status_type status_in;
    logic [31:0]    reg_rdata_out;
    logic           level_shift_output;
    logic           am_mark_out;
    logic           carrier_out;
    logic           frame_start_out;
    logic [31:0]    rd;
    logic [1:0]     exp_s [BITS_PER_FRAME];
    logic           synced     = 1'b0;
    int             frames;
    int             err_count  = 0;
    int             num_checks = 0;

    // Clock at 10 MHz
    always #50 clk_in = ~clk_in;

    // Generator and the receiving end
    tcg_time_code_generator #(.CARRIER_CYCLES(CC)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .sec_start_in(sec_start_in),
        .time_in(time_in), .status_in(status_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .level_shift_output(level_shift_output), .am_mark_out(am_mark_out),
        .carrier_out(carrier_out), .frame_start_out(frame_start_out)
    );
    tcg_rx_model #(.CARRIER_CYCLES(CC)) rx (
        .clk_in(clk_in), .level_in(level_shift_output),
        .frame_start_in(frame_start_out), .frames_out(frames)
    );

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic strobe();
        @(posedge clk_in);
        sec_start_in <= 1'b1;
        @(posedge clk_in);
        sec_start_in <= 1'b0;
    endtask
    // Place n bits of a field, least significant first
    task automatic put(input int pos, input logic [16:0] v, input int n);
        for (int i = 0; i < n; i++)
            exp_s[pos + i] = {1'b0, v[i]};
    endtask
    // Expected symbol list of one frame
    task automatic build(input tcg_mode_type m, input logic odd, qdis);
        logic par;
        logic pend;
        pend = (time_in.min == 7'h59) && (time_in.sec != 7'h00);
        par  = odd;
        for (int i = 0; i < BITS_PER_FRAME; i++)
            exp_s[i] = (i == 0 || i % 10 == 9) ? 2'd2 : 2'd0;
        put(1, time_in.sec[3:0], 4);
        put(6, time_in.sec[6:4], 3);
        put(10, time_in.min[3:0], 4);
        put(15, time_in.min[6:4], 3);
        put(20, time_in.hour[3:0], 4);
        put(25, time_in.hour[5:4], 2);
        put(30, time_in.doy[3:0], 4);
        put(35, time_in.doy[7:4], 4);
        put(40, time_in.doy[9:8], 2);
        if (m != TCG_B002 && m != TCG_B003) begin
            put(50, time_in.year[3:0], 4);
            put(55, time_in.year[7:4], 4);
        end
        if (m != TCG_B002 && m != TCG_B006) begin
            put(80, time_in.sbs[8:0], 9);
            put(90, time_in.sbs[16:9], 8);
        end
        if (m == TCG_AFNOR) begin
            put(60, time_in.dom, 6);
            put(70, time_in.month, 5);
        end
        if (m == TCG_IEEE || m == TCG_C37) begin
            put(60, pend & status_in.leap_pending_flag, 1);
            put(62, pend & status_in.saving_pending, 1);
            put(63, status_in.summer_time_flag, 1);
            put(64, status_in.tz_minus ^ (m == TCG_C37), 1);
            put(65, status_in.tz_hours, 4);
            put(70, status_in.tz_half, 1);
            put(71, (qdis | synced) ? QUAL_LOCKED : QUAL_FAILED, 4);
            for (int i = 0; i < 75; i++)
                par ^= (exp_s[i] == 2'd1);
            put(75, par, 1);
        end
    endtask
    task automatic cmp(input int lo, input int hi);
        for (int i = lo; i < hi; i++)
            check($sformatf("symbol %0d", i), rx.sym[i], exp_s[i]);
    endtask
    // Configure, launch one frame and compare what the receiver decoded
    task automatic run_frame(input tcg_mode_type m, input logic odd, qdis);
        int f;
        repeat (3 * CC) @(posedge clk_in);
        f = frames;
        reg_wr(CTRL_OFS, {25'h000_0000, 1'b1, qdis, odd, m});
        build(m, odd, qdis);
        strobe();
        for (int i = 0; i < FRAME_CYC + 100 && frames == f; i++)
            @(posedge clk_in);
        check("frame count", frames - f, 32'h0000_0001);
        cmp(0, 49);
        cmp(49, 60);
        cmp(60, 64);
        cmp(64, 71);
        cmp(71, 75);
        cmp(75, 100);
    endtask

    // Reset values, read-only status, unmapped place, strobe while disabled
    task automatic scen_regs();
        int f;
        f = frames;
        reg_rd(CTRL_OFS, rd);
        check("ctrl reset", rd, CTRL_RST);
        reg_rd(STATUS_OFS, rd);
        check("status reset", rd, 32'h0000_0000);
        reg_wr(STATUS_OFS, 32'hffff_ffff);
        reg_rd(STATUS_OFS, rd);
        check("status read only", rd, 32'h0000_0000);
        reg_rd(8'h08, rd);
        check("unmapped read", rd, 32'h0000_0000);
        reg_wr(CTRL_OFS, 32'hffff_ff85);
        reg_rd(CTRL_OFS, rd);
        check("ctrl upper bits", rd, 32'h0000_0005);
        strobe();
        repeat (5 * CC) @(posedge clk_in);
        check("disabled level", {31'h0, level_shift_output}, 32'h0000_0000);
        check("disabled frames", frames - f, 32'h0000_0000);
    endtask
    // Quality goes to locked on a short sync and stays there
    task automatic scen_sync();
        @(posedge clk_in);
        status_in.never_synced <= 1'b0;
        repeat (2) @(posedge clk_in);
        status_in.never_synced <= 1'b1;
        synced = 1'b1;
        time_in.min <= 7'h59;
        status_in.tz_minus <= 1'b1;
        run_frame(TCG_IEEE, 1'b1, 1'b0);
        reg_rd(STATUS_OFS, rd);
        check("synced flag", rd & 32'h0000_0080, 32'h0000_0080);
    endtask
    // Every plain variant and the date-carrying mode
    task automatic scen_variants();
        tcg_mode_type mv [5];
        mv = '{TCG_B002, TCG_B003, TCG_B006, TCG_B007, TCG_AFNOR};
        foreach (mv[i]) run_frame(mv[i], 1'b0, 1'b0);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        time_in   <= {7'h30, 7'h59, 6'h23, 10'h365, 8'h24, 6'h31, 5'h12,
                      17'h1_517f};
        status_in <= {1'b1, 1'b1, 1'b1, 1'b0, 4'h5, 1'b1, 1'b1};
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        scen_regs();
        run_frame(TCG_IEEE, 1'b0, 1'b0);
        time_in.min <= 7'h58;
        run_frame(TCG_C37, 1'b1, 1'b1);
        scen_sync();
        scen_variants();
        test_done();
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk_in);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
